/* File: digital_input_protection_mapper.sv */
// Purpose: maps configured digital input functions to protective actions
// Assumes: pins and PLC bits are synchronous to CORE_CLK_I; one scan per enabled cycle
// Notes:   per-input flags are registered once per scan; summaries are ORs of them, except the fuel level, which ORs the raw levels
//
// Contract
// - fuel-pump-stopping functions raise their anomaly and hold the pump off while active.
// - overridable functions raise unload/deactivate/interlock, or only a warning when bypassed.
// - emergency stop is active low; a low input raises an emergency alarm.
// - minimum fuel, overload, overspeed raise a fixed-text interlock.
// - low or high fuel level raise a fixed-text warning.
// - fuel level functions also feed the fuel pump management.
// - minimum oil pressure raises fixed-text interlock only after the masking time.
// - low oil, high and max coolant raise fixed-text warning only after masking.
// - mains parallel line open drops the mains-parallel state and alarms.
// - PLC-reserved inputs are kept from the sequence, visible only to the PLC.
// - not-used inputs have no effect on the sequence.
// - sixteen PLC-written virtual inputs are processed exactly like physical ones.
// - automatic-intervention-inhibit input active stops the engine.
// - generic alarm input raises a blocking alarm with configured text.
`timescale 1ns/1ps
module digital_input_protection_mapper
  import dimap_pkg::*;
(
  // clock and reset
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      ARST_N_I,
  input  wire logic                      CLK_EN_I,
  // input sources
  input  wire logic [PHYS_INPUTS-1:0]    PIN_STATE_I,
  input  wire logic [VIRT_INPUTS-1:0]    PLC_VIRT_STATE_I,
  input  wire func_type                  INPUT_FUNC_I [TOTAL_INPUTS],
  // engine context
  input  wire logic                      PROTECTION_BYPASS_I,
  input  wire logic                      PROTECTION_MASK_ELAPSED_I,
  // per-input anomalies for the display, each with its text source
  output logic [TOTAL_INPUTS-1:0]        WARNING_O,
  output logic [TOTAL_INPUTS-1:0]        UNLOAD_O,
  output logic [TOTAL_INPUTS-1:0]        DEACTIVATE_O,
  output logic [TOTAL_INPUTS-1:0]        INTERLOCK_O,
  output logic [TOTAL_INPUTS-1:0]        ALARM_O,
  output logic [TOTAL_INPUTS-1:0]        FIXED_TEXT_O,
  // sequencer summaries
  output logic                           EMERGENCY_O,
  output logic                           FUEL_PUMP_STOP_O,
  output logic                           ENGINE_STOP_O,
  output logic                           MAINS_PARALLEL_LOST_O,
  output fuel_level_type                 FUEL_LEVEL_O,
  // PLC view
  output logic [TOTAL_INPUTS-1:0]        PLC_INPUT_O,
  output logic [TOTAL_INPUTS-1:0]        INPUT_IN_USE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // per-input decode

  logic [TOTAL_INPUTS-1:0] state_all;
  action_type              act_now [TOTAL_INPUTS];
  action_type              act_d   [TOTAL_INPUTS];
  action_type              act_q   [TOTAL_INPUTS];
  fuel_level_type          fuel_d;
  fuel_level_type          fuel_q;
  logic [TOTAL_INPUTS-1:0] plc_d;
  logic [TOTAL_INPUTS-1:0] plc_q;
  logic [TOTAL_INPUTS-1:0] used_d;
  logic [TOTAL_INPUTS-1:0] used_q;

  // virtual inputs sit above the physical ones and get one decoder each
  assign state_all = {PLC_VIRT_STATE_I, PIN_STATE_I};

  for (genvar g = 0; g < TOTAL_INPUTS; g++) begin : g_dec
    dimap_decode u_dec (
      .func_i   (INPUT_FUNC_I[g]),
      .state_i  (state_all[g]),
      .bypass_i (PROTECTION_BYPASS_I),
      .masked_i (~PROTECTION_MASK_ELAPSED_I),
      .act_o    (act_now[g])
    );
  end

  always_comb begin
    fuel_d = '0;
    for (int i = 0; i < TOTAL_INPUTS; i++) begin
      act_d[i]  = act_now[i];
      plc_d[i]  = state_all[i];
      used_d[i] = (INPUT_FUNC_I[i] != input_not_used);
      // raw level handed on whatever the anomaly decision
      if (INPUT_FUNC_I[i] == fuel_level_minimum) fuel_d.minimum |= state_all[i];
      if (INPUT_FUNC_I[i] == fuel_level_low)     fuel_d.low     |= state_all[i];
      if (INPUT_FUNC_I[i] == fuel_level_high)    fuel_d.high    |= state_all[i];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < TOTAL_INPUTS; i++) act_q[i] <= ACTION_NONE;
      fuel_q <= '0;
      plc_q  <= '0;
      used_q <= '0;
    end else if (CLK_EN_I) begin
      for (int i = 0; i < TOTAL_INPUTS; i++) act_q[i] <= act_d[i];
      fuel_q <= fuel_d;
      plc_q  <= plc_d;
      used_q <= used_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from the registered per-input vectors and the registered fuel level

  always_comb begin
    EMERGENCY_O           = 1'b0;
    FUEL_PUMP_STOP_O      = 1'b0;
    ENGINE_STOP_O         = 1'b0;
    MAINS_PARALLEL_LOST_O = 1'b0;
    for (int i = 0; i < TOTAL_INPUTS; i++) begin
      WARNING_O[i]          = act_q[i].warning;
      UNLOAD_O[i]           = act_q[i].unload;
      DEACTIVATE_O[i]       = act_q[i].deactivate;
      INTERLOCK_O[i]        = act_q[i].interlock;
      ALARM_O[i]            = act_q[i].alarm;
      FIXED_TEXT_O[i]       = act_q[i].fixed_text;
      EMERGENCY_O           = EMERGENCY_O | act_q[i].emergency;
      FUEL_PUMP_STOP_O      = FUEL_PUMP_STOP_O | act_q[i].fuel_pump_stop;
      ENGINE_STOP_O         = ENGINE_STOP_O | act_q[i].engine_stop;
      MAINS_PARALLEL_LOST_O = MAINS_PARALLEL_LOST_O | act_q[i].mains_lost;
    end
  end

  assign FUEL_LEVEL_O   = fuel_q;
  assign PLC_INPUT_O    = plc_q;
  assign INPUT_IN_USE_O = used_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  property p_pump_stop;
    CLK_EN_I && INPUT_FUNC_I[0] == alarm_and_stop_fuel_pump && state_all[0]
      |=> FUEL_PUMP_STOP_O && ALARM_O[0] && !FIXED_TEXT_O[0];
  endproperty
  a_pump_stop: assert property (p_pump_stop) else $error("pump not stopped");

  property p_bypass;
    CLK_EN_I && INPUT_FUNC_I[1] == interlock_overridable && state_all[1]
      |=> WARNING_O[1] == $past(PROTECTION_BYPASS_I) && INTERLOCK_O[1] == !$past(PROTECTION_BYPASS_I);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass handling wrong");

  property p_estop;
    CLK_EN_I && INPUT_FUNC_I[2] == emergency_stop_input && !state_all[2] |=> EMERGENCY_O;
  endproperty
  a_estop: assert property (p_estop) else $error("emergency missed");

  property p_fixed_interlock;
    CLK_EN_I && INPUT_FUNC_I[3] == overspeed_input && state_all[3]
      |=> INTERLOCK_O[3] && FIXED_TEXT_O[3];
  endproperty
  a_fixed_interlock: assert property (p_fixed_interlock) else $error("overspeed interlock missing");

  property p_oil_mask;
    CLK_EN_I && INPUT_FUNC_I[4] == oil_pressure_minimum && !PROTECTION_MASK_ELAPSED_I
      |=> !INTERLOCK_O[4];
  endproperty
  a_oil_mask: assert property (p_oil_mask) else $error("oil interlock not masked");

  property p_coolant;
    CLK_EN_I && INPUT_FUNC_I[5] == coolant_temp_high && state_all[5] && PROTECTION_MASK_ELAPSED_I
      |=> WARNING_O[5] && FIXED_TEXT_O[5];
  endproperty
  a_coolant: assert property (p_coolant) else $error("coolant warning missing");

  property p_virtual_inhibit;
    CLK_EN_I && INPUT_FUNC_I[PHYS_INPUTS] == auto_intervention_inhibit && PLC_VIRT_STATE_I[0]
      |=> ENGINE_STOP_O;
  endproperty
  a_virtual_inhibit: assert property (p_virtual_inhibit) else $error("virtual inhibit ignored");

  property p_not_used;
    CLK_EN_I && INPUT_FUNC_I[6] == input_not_used
      |=> !WARNING_O[6] && !ALARM_O[6] && !INTERLOCK_O[6] && !INPUT_IN_USE_O[6];
  endproperty
  a_not_used: assert property (p_not_used) else $error("unused input acted");

  property p_freeze;
    !CLK_EN_I |=> $stable(ALARM_O) && $stable(PLC_INPUT_O);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_mains_open;
    CLK_EN_I && INPUT_FUNC_I[7] == mains_parallel_line_open && state_all[7]
      |=> MAINS_PARALLEL_LOST_O && ALARM_O[7] && !FIXED_TEXT_O[7];
  endproperty
  a_mains_open: assert property (p_mains_open) else $error("mains line open not acted on");

  property p_fuel_source;
    CLK_EN_I && INPUT_FUNC_I[8] == fuel_level_low && state_all[8]
      |=> FUEL_LEVEL_O.low && WARNING_O[8] && FIXED_TEXT_O[8];
  endproperty
  a_fuel_source: assert property (p_fuel_source) else $error("low fuel not passed on");

  // reserved inputs stay visible to the plc but must never reach the sequence
  property p_plc_reserved;
    CLK_EN_I && INPUT_FUNC_I[9] == plc_reserved_input
      |=> act_q[9].plc_only && INPUT_IN_USE_O[9] && PLC_INPUT_O[9] == $past(state_all[9])
          && !WARNING_O[9] && !ALARM_O[9] && !INTERLOCK_O[9] && !UNLOAD_O[9] && !DEACTIVATE_O[9];
  endproperty
  a_plc_reserved: assert property (p_plc_reserved) else $error("reserved input acted");

  property p_generic_alarm;
    CLK_EN_I && INPUT_FUNC_I[10] == generic_alarm_input && state_all[10]
      |=> ALARM_O[10] && !FIXED_TEXT_O[10];
  endproperty
  a_generic_alarm: assert property (p_generic_alarm) else $error("generic alarm missing");

  property p_virtual_copy;
    CLK_EN_I |=> PLC_INPUT_O[TOTAL_INPUTS-1:PHYS_INPUTS] == $past(PLC_VIRT_STATE_I);
  endproperty
  a_virtual_copy: assert property (p_virtual_copy) else $error("virtual inputs not taken");

  c_estop:    cover property (EMERGENCY_O);
  c_pump:     cover property (FUEL_PUMP_STOP_O && ENGINE_STOP_O);
  c_mains:    cover property (MAINS_PARALLEL_LOST_O);
  c_bypassed: cover property (PROTECTION_BYPASS_I && |WARNING_O);

endmodule : digital_input_protection_mapper

/* File: dimap_pkg.sv */
// Purpose: shared types and constants for the digital input protection mapper
// Assumes: one scan per enabled clock cycle
// Notes:   function codes are internal encodings of the input functions
package dimap_pkg;

  localparam int PHYS_INPUTS  = 16;
  localparam int VIRT_INPUTS  = 16;
  localparam int TOTAL_INPUTS = PHYS_INPUTS + VIRT_INPUTS;
  localparam int FUNC_WIDTH   = 5;

  typedef enum logic [FUNC_WIDTH-1:0] {
    input_not_used                = 5'h00,
    plc_reserved_input            = 5'h01,
    warn_and_stop_fuel_pump       = 5'h02,
    unload_and_stop_fuel_pump     = 5'h03,
    deactivate_and_stop_fuel_pump = 5'h04,
    alarm_and_stop_fuel_pump      = 5'h05,
    unload_overridable            = 5'h06,
    deactivate_overridable        = 5'h07,
    interlock_overridable         = 5'h08,
    emergency_stop_input          = 5'h09,
    fuel_level_minimum            = 5'h0A,
    fuel_level_low                = 5'h0B,
    fuel_level_high               = 5'h0C,
    oil_pressure_minimum          = 5'h0D,
    oil_pressure_low              = 5'h0E,
    coolant_temp_high             = 5'h0F,
    coolant_temp_maximum          = 5'h10,
    overload_input                = 5'h11,
    overspeed_input               = 5'h12,
    mains_parallel_line_open      = 5'h13,
    auto_intervention_inhibit     = 5'h14,
    generic_alarm_input           = 5'h15
  } func_type;

  // per-input anomaly vector; fixed_text set when the description is language fixed
  typedef struct packed {
    logic warning;
    logic unload;
    logic deactivate;
    logic interlock;
    logic alarm;
    logic emergency;
    logic fixed_text;
    logic fuel_pump_stop;
    logic engine_stop;
    logic mains_lost;
    logic plc_only;
  } action_type;

  localparam action_type ACTION_NONE = '0;

  typedef struct packed {
    logic minimum;
    logic low;
    logic high;
  } fuel_level_type;

endpackage : dimap_pkg

/* File: dimap_decode.sv */
// Purpose: maps one input's function and state to its anomaly actions
// Assumes: state is the sampled contact level, active high for every function except the emergency stop, which acts on a low level
// Notes:   purely combinational; registered by the parent
`timescale 1ns/1ps
module dimap_decode
  import dimap_pkg::*;
(
  // input under test
  input  wire func_type   func_i,
  input  wire logic       state_i,
  // engine context
  input  wire logic       bypass_i,
  input  wire logic       masked_i,
  // result
  output action_type      act_o
);

  always_comb begin
    act_o = ACTION_NONE;
    unique case (func_i)
      warn_and_stop_fuel_pump: begin
        act_o.warning        = state_i;
        act_o.fuel_pump_stop = state_i;
      end
      unload_and_stop_fuel_pump: begin
        act_o.unload         = state_i;
        act_o.fuel_pump_stop = state_i;
      end
      deactivate_and_stop_fuel_pump: begin
        act_o.deactivate     = state_i;
        act_o.fuel_pump_stop = state_i;
      end
      alarm_and_stop_fuel_pump: begin
        act_o.alarm          = state_i;
        act_o.fuel_pump_stop = state_i;
      end
      unload_overridable: begin
        act_o.unload  = state_i & ~bypass_i;
        act_o.warning = state_i & bypass_i;
      end
      deactivate_overridable: begin
        act_o.deactivate = state_i & ~bypass_i;
        act_o.warning    = state_i & bypass_i;
      end
      interlock_overridable: begin
        act_o.interlock = state_i & ~bypass_i;
        act_o.warning   = state_i & bypass_i;
      end
      emergency_stop_input: begin
        act_o.emergency  = ~state_i;
        act_o.fixed_text = ~state_i;
      end
      fuel_level_minimum, overload_input, overspeed_input: begin
        act_o.interlock  = state_i;
        act_o.fixed_text = state_i;
      end
      fuel_level_low, fuel_level_high: begin
        act_o.warning    = state_i;
        act_o.fixed_text = state_i;
      end
      oil_pressure_minimum: begin
        act_o.interlock  = state_i & ~masked_i;
        act_o.fixed_text = state_i & ~masked_i;
      end
      oil_pressure_low, coolant_temp_high, coolant_temp_maximum: begin
        act_o.warning    = state_i & ~masked_i;
        act_o.fixed_text = state_i & ~masked_i;
      end
      mains_parallel_line_open: begin
        act_o.mains_lost = state_i;
        act_o.alarm      = state_i;
      end
      plc_reserved_input: begin
        act_o.plc_only = 1'b1;
      end
      auto_intervention_inhibit: begin
        act_o.engine_stop = state_i;
      end
      generic_alarm_input: begin
        act_o.alarm = state_i;
      end
      input_not_used: begin
        act_o = ACTION_NONE;
      end
      default: begin
        act_o = ACTION_NONE;
      end
    endcase
  end

endmodule : dimap_decode

/* File: field_model.sv */
// Purpose: field contacts and PLC-written bits as seen by the mapper
// Assumes: contacts are clean levels, debounced upstream
// Notes:   levels only; the bench chooses when each contact moves
`timescale 1ns/1ps
module field_model (
  // levels requested by the bench
  input  wire logic [15:0] contact_i,
  input  wire logic [15:0] plc_i,
  // towards the mapper
  output logic      [15:0] pin_o,
  output logic      [15:0] virt_o
);
  assign pin_o  = contact_i;
  assign virt_o = plc_i;
endmodule : field_model

/* File: tb_top.sv */
// Purpose: self-checking bench for the digital input protection mapper
// Assumes: one scan per enabled clock edge, one cycle latency
// Notes:   inputs move on the falling edge, outputs checked one falling edge later
`timescale 1ns/1ps
module tb_top
  import dimap_pkg::*;
;
  logic                    clk;
  logic                    arst_n;
  logic                    en;
  logic                    byp;
  logic                    msk;
  logic [15:0]             con;
  logic [15:0]             plc;
  logic [15:0]             pin;
  logic [15:0]             virt;
  func_type                fn [TOTAL_INPUTS];
  logic [TOTAL_INPUTS-1:0] warn_o, unl_o, dea_o, ilk_o, alm_o, fix_o, plcin_o, use_o;
  logic                    emg_o, pump_o, eng_o, mains_o;
  fuel_level_type          lvl_o;
  logic [TOTAL_INPUTS-1:0] e_w, e_u, e_d, e_i, e_a, e_f, e_p, e_n;
  logic [6:0]              e_s;
  int                      err_total;
  int                      comparisons;

  field_model i_field (.contact_i(con), .plc_i(plc), .pin_o(pin), .virt_o(virt));

  digital_input_protection_mapper i_dut (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .CLK_EN_I(en), .PIN_STATE_I(pin), .PLC_VIRT_STATE_I(virt),
    .INPUT_FUNC_I(fn), .PROTECTION_BYPASS_I(byp), .PROTECTION_MASK_ELAPSED_I(msk),
    .WARNING_O(warn_o), .UNLOAD_O(unl_o), .DEACTIVATE_O(dea_o), .INTERLOCK_O(ilk_o), .ALARM_O(alm_o),
    .FIXED_TEXT_O(fix_o), .EMERGENCY_O(emg_o), .FUEL_PUMP_STOP_O(pump_o), .ENGINE_STOP_O(eng_o),
    .MAINS_PARALLEL_LOST_O(mains_o), .FUEL_LEVEL_O(lvl_o), .PLC_INPUT_O(plcin_o), .INPUT_IN_USE_O(use_o));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic action_type exp_act(func_type f, logic s, logic b, logic m);
    action_type a;
    a = ACTION_NONE;
    case (f)
      warn_and_stop_fuel_pump:       {a.warning, a.fuel_pump_stop} = {2{s}};
      unload_and_stop_fuel_pump:     {a.unload, a.fuel_pump_stop} = {2{s}};
      deactivate_and_stop_fuel_pump: {a.deactivate, a.fuel_pump_stop} = {2{s}};
      alarm_and_stop_fuel_pump:      {a.alarm, a.fuel_pump_stop} = {2{s}};
      unload_overridable:            {a.warning, a.unload} = {s & b, s & ~b};
      deactivate_overridable:        {a.warning, a.deactivate} = {s & b, s & ~b};
      interlock_overridable:         {a.warning, a.interlock} = {s & b, s & ~b};
      emergency_stop_input:          {a.emergency, a.fixed_text} = {2{~s}};
      fuel_level_minimum, overload_input, overspeed_input: {a.interlock, a.fixed_text} = {2{s}};
      fuel_level_low, fuel_level_high: {a.warning, a.fixed_text} = {2{s}};
      oil_pressure_minimum:          {a.interlock, a.fixed_text} = {2{s & m}};
      oil_pressure_low, coolant_temp_high, coolant_temp_maximum: {a.warning, a.fixed_text} = {2{s & m}};
      mains_parallel_line_open:      {a.alarm, a.mains_lost} = {2{s}};
      auto_intervention_inhibit:     a.engine_stop = s;
      generic_alarm_input:           a.alarm = s;
      default:                       a = ACTION_NONE;
    endcase
    return a;
  endfunction : exp_act

  task automatic predict();
    action_type a;
    logic       s;
    e_s = '0;
    for (int i = 0; i < TOTAL_INPUTS; i++) begin
      s = (i < PHYS_INPUTS) ? pin[i] : virt[i-PHYS_INPUTS];
      a = exp_act(fn[i], s, byp, msk);
      {e_w[i], e_u[i], e_d[i], e_i[i], e_a[i], e_f[i]} =
        {a.warning, a.unload, a.deactivate, a.interlock, a.alarm, a.fixed_text};
      e_p[i] = s;
      e_n[i] = (fn[i] != input_not_used);
      e_s |= {a.emergency, a.fuel_pump_stop, a.engine_stop, a.mains_lost,
              s & (fn[i] == fuel_level_minimum), s & (fn[i] == fuel_level_low), s & (fn[i] == fuel_level_high)};
    end
  endtask : predict

  task automatic cmp(logic [TOTAL_INPUTS-1:0] got, logic [TOTAL_INPUTS-1:0] exp, string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic check_all();
    cmp(warn_o, e_w, "warning");
    cmp(unl_o, e_u, "unload");
    cmp(dea_o, e_d, "deactivate");
    cmp(ilk_o, e_i, "interlock");
    cmp(alm_o, e_a, "alarm");
    cmp(fix_o, e_f, "fixed text");
    cmp(plcin_o, e_p, "plc copy");
    cmp(use_o, e_n, "in use");
    cmp({25'h0, emg_o, pump_o, eng_o, mains_o, lvl_o}, {25'h0, e_s}, "summary");
  endtask : check_all

  // predict from what was driven, let one scan edge pass, then compare
  task automatic step();
    // the field model is a continuous path: let it settle before predicting
    #1;
    if (en) predict();
    @(negedge clk);
    check_all();
  endtask : step

  task automatic rnd_all();
    con = 16'($urandom);
    plc = 16'($urandom);
    byp = 1'($urandom_range(1));
    msk = 1'($urandom_range(1));
    foreach (fn[i]) fn[i] = func_type'(5'($urandom_range(21)));
  endtask : rnd_all

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // about 500 scans expected; ten times that before giving up
  initial begin
    #20000;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    {arst_n, en, byp, msk, con, plc} = '0;
    err_total = 0;
    comparisons = 0;
    {e_w, e_u, e_d, e_i, e_a, e_f, e_p, e_n, e_s} = '0;
    foreach (fn[i]) fn[i] = input_not_used;
    void'($urandom(14803));
    en = 1'b1;
    repeat (10) @(negedge clk);
    check_all();
    arst_n = 1'b1;
    // every function on a pin and on a virtual input, every context
    for (int f = 0; f <= 21; f++) begin
      for (int k = 0; k < 8; k++) begin
        fn[3] = func_type'(f[4:0]);
        fn[19] = func_type'(f[4:0]);
        {byp, msk, con[3], plc[3]} = {k[1], k[2], k[0], ~k[0]};
        step();
      end
    end
    $display("test all functions done");
    repeat (300) begin
      rnd_all();
      step();
    end
    $display("test random scans done");
    // a frozen scan must hold the last results whatever the inputs do
    en = 1'b0;
    rnd_all();
    step();
    en = 1'b1;
    step();
    $display("test clock enable done");
    arst_n = 1'b0;
    #1;
    {e_w, e_u, e_d, e_i, e_a, e_f, e_p, e_n, e_s} = '0;
    check_all();
    @(negedge clk);
    arst_n = 1'b1;
    rnd_all();
    step();
    $display("test mid-run reset done");
    conclude();
  end
endmodule : tb_top
